// ===== hdl/cpu_core_status_registers.sv
// Core status registers with an AXI4-Lite slave and an execution-unit port
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module cpu_core_status_registers
  import core_regs_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write channels
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Execution unit requests
  input  wire logic              exec_valid,
  input  wire exec_op_type       exec_op,
  input  wire logic [7:0]        exec_first,
  input  wire logic [7:0]        exec_second,
  // Register contents to the core
  output logic [7:0]             accumulator,
  output logic [7:0]             second_operand,
  output logic [7:0]             stack_pointer,
  output logic [15:0]            data_pointer_16,
  output logic [7:0]             program_status_word,
  output logic                   parity_flag,
  output logic [7:0]             bank_base,
  // Scratch-pad write for pushes
  output logic                   ram_wr_en,
  output logic [7:0]             ram_wr_addr,
  output logic [7:0]             ram_wr_data
);

  localparam int IW = ADDR_W - 2;

  // ==========================================================================
  // State
  typedef struct packed {
    logic [7:0]    acc;
    logic [7:0]    b;
    logic [7:0]    sp;
    logic [7:0]    data_pointer_low;
    logic [7:0]    data_pointer_high;
    logic          cy;
    logic          ac;
    logic          f0;
    logic [1:0]    rs;
    logic          ov;
    logic          f1;
    logic          ram_we;
    logic [7:0]    ram_addr;
    logic [7:0]    ram_data;
    logic          aw_have;
    logic          w_have;
    logic [IW-1:0] widx;
    logic [7:0]    wdata;
    logic          wlane;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          rvalid;
    logic [7:0]    rdata;
    logic [1:0]    rresp;
  } state_type;

  state_type     st_q;
  state_type     st_d;
  logic          commit;
  logic [IW-1:0] ridx;
  logic          par;
  logic [7:0]    psw_word;

  flag_calc_if fc ();

  flag_calc u_calc (
    .fc (fc.calc)
  );

  // ==========================================================================
  // Calculator hookup
  assign fc.op     = exec_valid ? exec_op : OP_NONE;
  assign fc.acc    = st_q.acc;
  assign fc.b      = st_q.b;
  assign fc.first  = exec_first;
  assign fc.second = exec_second;
  assign fc.cy_in  = st_q.cy;
  assign fc.ac_in  = st_q.ac;
  assign fc.ov_in  = st_q.ov;

  // Parity is derived live, never stored, so it cannot go stale
  assign par      = ^st_q.acc;
  assign psw_word = {st_q.cy, st_q.ac, st_q.f0, st_q.rs, st_q.ov, st_q.f1, par};
  assign commit   = st_q.aw_have && st_q.w_have;
  assign ridx     = s_axi_araddr[ADDR_W-1:2];

  // ==========================================================================
  // Next state: hardware first, software after so that it wins
  always_comb begin
    st_d        = st_q;
    st_d.ram_we = 1'b0;
    if (exec_valid) begin
      st_d.acc = fc.res_acc;
      st_d.b   = fc.res_b;
      st_d.cy  = fc.cy;
      st_d.ac  = fc.ac;
      st_d.ov  = fc.ov;
      if (exec_op == OP_PUSH) begin
        st_d.sp       = st_q.sp + 8'h01;
        st_d.ram_we   = 1'b1;
        st_d.ram_addr = st_q.sp + 8'h01;
        st_d.ram_data = exec_first;
      end else if (exec_op == OP_POP) begin
        st_d.sp = st_q.sp - 8'h01;
      end
    end
    // Bus answers retire on their handshakes
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
    // Address and data are caught in either order
    if (s_axi_awvalid && s_axi_awready) begin
      st_d.aw_have = 1'b1;
      st_d.widx    = s_axi_awaddr[ADDR_W-1:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_d.w_have = 1'b1;
      st_d.wdata  = s_axi_wdata[7:0];
      st_d.wlane  = s_axi_wstrb[0];
    end
    // Write commit; only byte lane 0 carries register data
    if (commit) begin
      st_d.aw_have = 1'b0;
      st_d.w_have  = 1'b0;
      st_d.bvalid  = 1'b1;
      st_d.bresp   = RESP_OKAY;
      case (st_q.widx)
        IW'(ACC_IDX): if (st_q.wlane) st_d.acc = st_q.wdata;
        IW'(B_IDX):   if (st_q.wlane) st_d.b = st_q.wdata;
        IW'(SP_IDX):  if (st_q.wlane) st_d.sp = st_q.wdata;
        IW'(DPL_IDX): if (st_q.wlane) st_d.data_pointer_low = st_q.wdata;
        IW'(DPH_IDX): if (st_q.wlane) st_d.data_pointer_high = st_q.wdata;
        IW'(PSW_IDX): begin
          if (st_q.wlane) begin
            st_d.cy = st_q.wdata[CY_BIT];
            st_d.ac = st_q.wdata[AC_BIT];
            st_d.f0 = st_q.wdata[F0_BIT];
            st_d.rs = st_q.wdata[RS1_BIT:RS0_BIT];
            st_d.ov = st_q.wdata[OV_BIT];
            st_d.f1 = st_q.wdata[F1_BIT];
          end
        end
        default: st_d.bresp = RESP_SLVERR;
      endcase
    end
    // Read sampled at the taking edge
    if (s_axi_arvalid && s_axi_arready) begin
      st_d.rvalid = 1'b1;
      st_d.rresp  = RESP_OKAY;
      case (ridx)
        IW'(ACC_IDX): st_d.rdata = st_q.acc;
        IW'(B_IDX):   st_d.rdata = st_q.b;
        IW'(SP_IDX):  st_d.rdata = st_q.sp;
        IW'(DPL_IDX): st_d.rdata = st_q.data_pointer_low;
        IW'(DPH_IDX): st_d.rdata = st_q.data_pointer_high;
        IW'(PSW_IDX): st_d.rdata = psw_word;
        default: begin
          st_d.rdata = 8'h00;
          st_d.rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  // ==========================================================================
  // Register stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q     <= '0;
      st_q.acc <= ACC_RST;
      st_q.b   <= B_RST;
      st_q.sp  <= SP_RST;
      st_q.data_pointer_low <= DPL_RST;
      st_q.data_pointer_high <= DPH_RST;
      {st_q.cy, st_q.ac, st_q.f0, st_q.rs, st_q.ov, st_q.f1} <= PSW_RST[7:1];
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // Outputs; one outstanding answer per direction keeps the slave simple
  assign s_axi_awready       = !st_q.aw_have && !st_q.bvalid;
  assign s_axi_wready        = !st_q.w_have && !st_q.bvalid;
  assign s_axi_bvalid        = st_q.bvalid;
  assign s_axi_bresp         = st_q.bresp;
  assign s_axi_arready       = !st_q.rvalid;
  assign s_axi_rvalid        = st_q.rvalid;
  assign s_axi_rresp         = st_q.rresp;
  assign s_axi_rdata         = {24'h000000, st_q.rdata};
  assign accumulator         = st_q.acc;
  assign second_operand      = st_q.b;
  assign stack_pointer       = st_q.sp;
  assign data_pointer_16     = {st_q.data_pointer_high, st_q.data_pointer_low};
  assign program_status_word = psw_word;
  assign parity_flag         = par;
  assign bank_base           = {3'h0, st_q.rs, 3'h0};
  assign ram_wr_en           = st_q.ram_we;
  assign ram_wr_addr         = st_q.ram_addr;
  assign ram_wr_data         = st_q.ram_data;

  // ==========================================================================
  // Checks
  logic        psw_sw;
  logic        sp_sw;
  logic        ab_sw;
  logic        dpl_sw;
  logic [8:0]  add_ref;
  logic [7:0]  sev_ref;
  logic [4:0]  nib_ref;
  logic [15:0] mul_ref;
  logic        mul_big;
  logic        cmp_lt;
  logic [1:0]  wdata_rs;

  assign psw_sw   = commit && st_q.widx == IW'(PSW_IDX) && st_q.wlane;
  assign sp_sw    = commit && st_q.widx == IW'(SP_IDX) && st_q.wlane;
  assign dpl_sw   = commit && st_q.widx == IW'(DPL_IDX) && st_q.wlane;
  assign ab_sw    = commit && (st_q.widx == IW'(ACC_IDX) || st_q.widx == IW'(B_IDX));
  assign add_ref  = {1'b0, st_q.acc} + {1'b0, exec_second};
  assign sev_ref  = {1'b0, st_q.acc[6:0]} + {1'b0, exec_second[6:0]};
  assign nib_ref  = {1'b0, st_q.acc[3:0]} + {1'b0, exec_second[3:0]};
  assign mul_ref  = 16'(st_q.acc) * 16'(st_q.b);
  assign mul_big  = mul_ref > BYTE_MAX;
  assign cmp_lt   = exec_first < exec_second;
  assign wdata_rs = st_q.wdata[RS1_BIT:RS0_BIT];

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence add_req;
    exec_valid && exec_op == OP_ADD && !psw_sw;
  endsequence
  sequence push_req;
    exec_valid && exec_op == OP_PUSH && !sp_sw;
  endsequence

  a_push_order: assert property (push_req |=> ram_wr_en && ram_wr_addr == st_q.sp
                                 && st_q.sp == $past(st_q.sp) + 8'h01) else $error("push order wrong");
  a_reset_values: assert property ($rose(aresetn) |-> st_q.sp == SP_RST && st_q.acc == ACC_RST
                                   && st_q.b == B_RST && st_q.data_pointer_low == DPL_RST) else $error("bad reset");
  a_reset_status: assert property ($rose(aresetn) |-> program_status_word == PSW_RST)
    else $error("status word not cleared");
  a_data_pointer_16_join: assert property (dpl_sw |=> data_pointer_16[7:0] == $past(st_q.wdata)
                                && data_pointer_16[15:8] == $past(st_q.data_pointer_high)) else $error("pointer join wrong");
  a_add_carry: assert property (add_req |=> st_q.cy == $past(add_ref[8])) else $error("add carry wrong");
  a_add_aux: assert property (add_req |=> st_q.ac == $past(nib_ref[4])) else $error("aux carry wrong");
  a_add_ovf: assert property (add_req |=> st_q.ov == ($past(add_ref[8]) ^ $past(sev_ref[7])))
    else $error("add overflow wrong");
  a_muldiv_carry: assert property (exec_valid && (exec_op == OP_MUL || exec_op == OP_DIV) && !psw_sw
                                   |=> !st_q.cy) else $error("carry not cleared");
  a_cjne_carry: assert property (exec_valid && exec_op == OP_CJNE && !psw_sw |=> st_q.cy == $past(cmp_lt))
    else $error("compare carry wrong");
  a_da_carry: assert property (exec_valid && exec_op == OP_DA && st_q.acc > BCD_BYTE_MAX && !psw_sw
                               |=> st_q.cy) else $error("decimal carry missing");
  a_bank_select: assert property (psw_sw |=> bank_base == {3'h0, $past(wdata_rs), 3'h0})
    else $error("bank base wrong");
  a_user_flags: assert property (!psw_sw |=> st_q.f0 == $past(st_q.f0) && st_q.f1 == $past(st_q.f1))
    else $error("user flag moved");
  a_mul_result: assert property (exec_valid && exec_op == OP_MUL && !ab_sw
                                 |=> {st_q.b, st_q.acc} == $past(mul_ref)) else $error("product wrong");
  a_mul_ovf: assert property (exec_valid && exec_op == OP_MUL && !psw_sw |=> st_q.ov == $past(mul_big))
    else $error("multiply overflow wrong");
  a_parity_read: assert property (s_axi_arvalid && s_axi_arready && ridx == IW'(PSW_IDX)
                                  |=> s_axi_rdata[P_BIT] == $past(par)) else $error("parity wrong");
  a_sw_priority: assert property (psw_sw && exec_valid && exec_op == OP_ADD
                                  |=> st_q.cy == $past(st_q.wdata[CY_BIT])) else $error("software lost");

endmodule

// ===== common/core_regs_pkg.sv
// Constants and types shared by the core status register block
package core_regs_pkg;

  // ==========================================================================
  // Register indices; byte address on the bus is four times the index
  localparam logic [7:0] SP_IDX  = 8'h81;
  localparam logic [7:0] DPL_IDX = 8'h82;
  localparam logic [7:0] DPH_IDX = 8'h83;
  localparam logic [7:0] PSW_IDX = 8'hd0;
  localparam logic [7:0] ACC_IDX = 8'he0;
  localparam logic [7:0] B_IDX   = 8'hf0;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] SP_RST  = 8'h07;
  localparam logic [7:0] DPL_RST = 8'h00;
  localparam logic [7:0] DPH_RST = 8'h00;
  localparam logic [7:0] PSW_RST = 8'h00;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] B_RST   = 8'h00;

  // ==========================================================================
  // Status word bit positions
  localparam int CY_BIT  = 7;
  localparam int AC_BIT  = 6;
  localparam int F0_BIT  = 5;
  localparam int RS1_BIT = 4;
  localparam int RS0_BIT = 3;
  localparam int OV_BIT  = 2;
  localparam int F1_BIT  = 1;
  localparam int P_BIT   = 0;

  // ==========================================================================
  // Arithmetic constants
  localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
  localparam logic [7:0] BCD_BYTE_MAX  = 8'h99;
  localparam logic [8:0] DA_LO_ADD     = 9'h006;
  localparam logic [8:0] DA_HI_ADD     = 9'h060;
  localparam logic [15:0] BYTE_MAX     = 16'h00ff;

  // ==========================================================================
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Operations requested by the execution unit
  typedef enum logic [3:0] {
    OP_NONE, OP_ADD, OP_ADDC, OP_SUBB, OP_MUL, OP_DIV, OP_CJNE, OP_DA, OP_PUSH, OP_POP
  } exec_op_type;

endpackage

// ===== common/flag_calc_if.sv
// Operand and result bundle between the register block and its calculator
`timescale 1ns/1ps
interface flag_calc_if;
  import core_regs_pkg::*;

  // Operands and current flags
  exec_op_type op;
  logic [7:0]  acc;
  logic [7:0]  b;
  logic [7:0]  first;
  logic [7:0]  second;
  logic        cy_in;
  logic        ac_in;
  logic        ov_in;
  // Results
  logic [7:0]  res_acc;
  logic [7:0]  res_b;
  logic        cy;
  logic        ac;
  logic        ov;

  modport calc (input op, acc, b, first, second, cy_in, ac_in, ov_in,
                output res_acc, res_b, cy, ac, ov);
  modport user (output op, acc, b, first, second, cy_in, ac_in, ov_in,
                input res_acc, res_b, cy, ac, ov);
endinterface

// ===== hdl/flag_calc.sv
// Combinational result and flag calculator for the arithmetic operations
`timescale 1ns/1ps
module flag_calc
  import core_regs_pkg::*;
(
  // Operands in, results out
  flag_calc_if.calc fc
);

  // ==========================================================================
  // Adder slices
  logic        sub;
  logic        cin;
  logic [4:0]  nib;
  logic [7:0]  sev;
  logic [8:0]  full;
  logic [15:0] prod;
  logic        da_lo_adj;
  logic        da_hi_adj;
  logic [8:0]  da_lo;
  logic [8:0]  da_hi;

  assign sub = (fc.op == OP_SUBB);
  assign cin = (fc.op != OP_ADD) && fc.cy_in;

  // Three widths of one sum give the carries out of bits 3, 6 and 7
  assign nib  = sub ? {1'b0, fc.acc[3:0]} - {1'b0, fc.second[3:0]} - {4'h0, cin}
                    : {1'b0, fc.acc[3:0]} + {1'b0, fc.second[3:0]} + {4'h0, cin};
  assign sev  = sub ? {1'b0, fc.acc[6:0]} - {1'b0, fc.second[6:0]} - {7'h00, cin}
                    : {1'b0, fc.acc[6:0]} + {1'b0, fc.second[6:0]} + {7'h00, cin};
  assign full = sub ? {1'b0, fc.acc} - {1'b0, fc.second} - {8'h00, cin}
                    : {1'b0, fc.acc} + {1'b0, fc.second} + {8'h00, cin};
  assign prod = 16'(fc.acc) * 16'(fc.b);

  // Decimal adjust in two steps; the high step also catches a low-step carry
  assign da_lo_adj = fc.ac_in || (fc.acc[3:0] > BCD_DIGIT_MAX);
  assign da_lo     = {1'b0, fc.acc} + (da_lo_adj ? DA_LO_ADD : 9'h000);
  assign da_hi_adj = fc.cy_in || da_lo[8] || (da_lo[7:4] > BCD_DIGIT_MAX);
  assign da_hi     = da_lo + (da_hi_adj ? DA_HI_ADD : 9'h000);

  // Unaffected values pass through unchanged
  always_comb begin
    fc.res_acc = fc.acc;
    fc.res_b   = fc.b;
    fc.cy      = fc.cy_in;
    fc.ac      = fc.ac_in;
    fc.ov      = fc.ov_in;
    unique case (fc.op)
      OP_ADD, OP_ADDC, OP_SUBB: begin
        fc.res_acc = full[7:0];
        fc.cy      = full[8];
        fc.ac      = nib[4];
        fc.ov      = full[8] ^ sev[7];
      end
      OP_MUL: begin
        fc.res_acc = prod[7:0];
        fc.res_b   = prod[15:8];
        fc.cy      = 1'b0;
        fc.ov      = (prod > BYTE_MAX);
      end
      OP_DIV: begin
        fc.cy = 1'b0;
        // Divide by zero leaves both operands alone and flags overflow
        fc.ov = (fc.b == 8'h00);
        if (fc.b != 8'h00) begin
          fc.res_acc = fc.acc / fc.b;
          fc.res_b   = fc.acc % fc.b;
        end
      end
      OP_CJNE: begin
        fc.cy = (fc.first < fc.second);
      end
      OP_DA: begin
        fc.res_acc = da_hi[7:0];
        fc.cy      = da_hi_adj || da_hi[8];
      end
      default: begin
      end
    endcase
  end

endmodule

// ===== verif/exec_unit_model.sv
// Execution unit stand-in: issues operations and records scratch-pad writes
`timescale 1ns/1ps
module exec_unit_model
  import core_regs_pkg::*;
(
  // Clock
  input  wire logic       aclk,
  // Requests to the register block
  output logic            exec_valid,
  output exec_op_type     exec_op,
  output logic [7:0]      exec_first,
  output logic [7:0]      exec_second,
  // Scratch-pad write port
  input  wire logic       ram_wr_en,
  input  wire logic [7:0] ram_wr_addr,
  input  wire logic [7:0] ram_wr_data
);
  logic [7:0] last_addr;
  logic [7:0] last_data;

  // ==========================================================================
  // Idle from time zero
  initial begin
    exec_valid  = 1'b0;
    exec_op     = OP_NONE;
    exec_first  = 8'h00;
    exec_second = 8'h00;
  end

  // One op per call; operands flip afterwards so stale values never look valid
  task automatic issue(input exec_op_type op, input logic [7:0] f, input logic [7:0] s);
    @(posedge aclk);
    exec_valid  <= 1'b1;
    exec_op     <= op;
    exec_first  <= f;
    exec_second <= s;
    @(posedge aclk);
    exec_valid  <= 1'b0;
    exec_op     <= OP_NONE;
    exec_first  <= ~f;
    exec_second <= ~s;
  endtask

  // Keep the last pushed byte and its address
  always @(posedge aclk) begin
    if (ram_wr_en) begin
      last_addr <= ram_wr_addr;
      last_data <= ram_wr_data;
    end
  end
endmodule

// ===== verif/cpu_core_status_registers_test.sv
// Self-checking bench for the core status register block
`timescale 1ns/1ps
module cpu_core_status_registers_test;
  import core_regs_pkg::*;

  // ==========================================================================
  // Signals and model state
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        exec_valid, parity_flag, ram_wr_en;
  exec_op_type exec_op;
  logic [7:0]  exec_first, exec_second, accumulator, second_operand, stack_pointer;
  logic [7:0]  program_status_word, bank_base, ram_wr_addr, ram_wr_data, f, s;
  logic [15:0] data_pointer_16;
  logic [15:0] rnd = 16'h002a;
  int          bad_count = 0, samples_checked = 0;
  int          m_acc = 0, m_b = 0, m_sp = 7, m_dpl = 0, m_dph = 0, m_psw = 0;
  int          tab[6] = '{SP_IDX, DPL_IDX, DPH_IDX, PSW_IDX, ACC_IDX, B_IDX};

  cpu_core_status_registers #(.ADDR_W(12)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .exec_valid, .exec_op, .exec_first, .exec_second,
    .accumulator, .second_operand, .stack_pointer, .data_pointer_16, .program_status_word,
    .parity_flag, .bank_base, .ram_wr_en, .ram_wr_addr, .ram_wr_data);
  exec_unit_model xu (.aclk, .exec_valid, .exec_op, .exec_first, .exec_second, .ram_wr_en,
    .ram_wr_addr, .ram_wr_data);

  // 100 ns period
  always #50 aclk = ~aclk;

  // ==========================================================================
  // Helpers
  function automatic logic [7:0] next();
    rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
    return rnd[7:0];
  endfunction

  function automatic int mval(input int idx);
    case (idx)
      SP_IDX:  return m_sp;
      DPL_IDX: return m_dpl;
      DPH_IDX: return m_dph;
      PSW_IDX: return (m_psw & 8'hfe) | ^m_acc[7:0];
      ACC_IDX: return m_acc;
      default: return m_b;
    endcase
  endfunction

  task automatic stop_test();
    $display("Compared %0d values, %0d mismatches", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // A wait that ran out ends the run
  task automatic guard(input int n);
    if (n >= 60) begin
      bad_count++;
      stop_test();
    end
  endtask

  // ==========================================================================
  // Bus master; each valid drops at the edge its ready is seen
  task automatic axi_write(input int idx, input logic [7:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr  <= 12'(idx * 4);
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 60);
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
    guard(n);
  endtask

  task automatic get(input int idx, input int exp, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr  <= 12'(idx * 4);
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 60);
    s_axi_rready <= 1'b0;
    check(s_axi_rdata, exp);
    check(s_axi_rresp, er);
    guard(n);
  endtask

  task automatic put(input int idx, input logic [7:0] d);
    axi_write(idx, d, rsp);
    check(rsp, RESP_OKAY);
    case (idx)
      SP_IDX:  m_sp = d;
      DPL_IDX: m_dpl = d;
      DPH_IDX: m_dph = d;
      PSW_IDX: m_psw = d;
      ACC_IDX: m_acc = d;
      default: m_b = d;
    endcase
  endtask

  // Register outputs against the model
  task automatic cmp_regs();
    check(accumulator, m_acc);
    check(second_operand, m_b);
    check(stack_pointer, m_sp);
    check(data_pointer_16, m_dph * 256 + m_dpl);
    check(program_status_word, mval(PSW_IDX));
    check(parity_flag, ^m_acc[7:0]);
    check(bank_base, (m_psw >> 3 & 3) * 8);
  endtask

  // Flag and result model for one execution-unit op
  task automatic model_op(input int op, input int fv, input int sv);
    int cy, ac, ov, r, c6;
    cy = m_psw[7];
    ac = m_psw[6];
    ov = m_psw[2];
    if (op == 1) cy = 0;
    case (op)
      1, 2: begin
        ac = (m_acc & 8'h0f) + (sv & 8'h0f) + cy > 8'h0f;
        c6 = (m_acc & 8'h7f) + (sv & 8'h7f) + cy > 8'h7f;
        r = m_acc + sv + cy;
        cy = r > 8'hff;
        ov = cy ^ c6;
        m_acc = r & 8'hff;
      end
      3: begin
        ac = (m_acc & 8'h0f) < (sv & 8'h0f) + cy;
        c6 = (m_acc & 8'h7f) < (sv & 8'h7f) + cy;
        r = m_acc - sv - cy;
        cy = r < 0;
        ov = cy ^ c6;
        m_acc = r & 8'hff;
      end
      4: begin
        r = m_acc * m_b;
        m_acc = r & 8'hff;
        m_b = r >> 8;
        cy = 0;
        ov = r > 8'hff;
      end
      5: begin
        cy = 0;
        ov = m_b == 0;
        if (m_b != 0) begin
          r = m_acc / m_b;
          m_b = m_acc % m_b;
          m_acc = r;
        end
      end
      6: cy = fv < sv;
      7: begin
        r = m_acc;
        if ((r & 8'h0f) > 9 || ac) r = r + 8'h06;
        if (r > 8'hff) cy = 1;
        if ((r >> 4 & 8'h0f) > 9 || cy) r = r + 8'h60;
        if (r > 8'hff) cy = 1;
        m_acc = r & 8'hff;
      end
      8: m_sp = (m_sp + 1) & 8'hff;
      default: m_sp = (m_sp - 1) & 8'hff;
    endcase
    m_psw = (m_psw & 8'h3a) | (cy << 7) | (ac << 6) | (ov << 2);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (tab[i]) get(tab[i], mval(tab[i]), RESP_OKAY);
    check(stack_pointer, 8'h07);
    get(8'h85, 0, RESP_SLVERR);
    axi_write(8'h85, next(), rsp);
    check(rsp, RESP_SLVERR);
    // Lane 0 off: answered OKAY and the register is left alone
    s_axi_wstrb <= 4'he;
    axi_write(ACC_IDX, next(), rsp);
    s_axi_wstrb <= 4'hf;
    check(rsp, RESP_OKAY);
    get(ACC_IDX, mval(ACC_IDX), RESP_OKAY);
    // Random write and readback of every register
    repeat (3) begin
      foreach (tab[i]) begin
        put(tab[i], next());
        get(tab[i], mval(tab[i]), RESP_OKAY);
      end
      #10 cmp_regs();
    end
    // Every op in turn; divide by zero and pointer wrap included
    for (int i = 0; i < 45; i++) begin
      put(ACC_IDX, next());
      put(B_IDX, (i == 13) ? 8'h00 : next());
      put(PSW_IDX, next());
      if (i == 16) put(SP_IDX, 8'hff);
      f = next();
      s = next();
      xu.issue(exec_op_type'(4'(1 + i % 9)), f, s);
      model_op(1 + i % 9, f, s);
      @(posedge aclk);
      #10 cmp_regs();
      check(ram_wr_en, 1'b0);
      if (i % 9 == 7) begin
        check(xu.last_addr, m_sp);
        check(xu.last_data, f);
      end
    end
    // Status word write and a hardware add land on the same edge; software must win
    repeat (4) begin
      f = next();
      s = next();
      fork
        axi_write(PSW_IDX, f, rsp);
        begin
          @(posedge aclk);
          xu.issue(OP_ADD, f, s);
        end
      join
      check(rsp, RESP_OKAY);
      model_op(1, f, s);
      m_psw = f;
      #10 cmp_regs();
    end
    stop_test();
  end
endmodule
